// ===== hdl/tdp_pkg.sv
// package: register map, field layout and states of the transmit descriptor pointer tracker
package tdp_pkg;
   localparam logic [7:0] TDP_CMD_OFS = 8'h00;
   localparam logic [7:0] TDP_PTR_OFS = 8'h20;
   localparam logic [7:0] TDP_STAT_OFS = 8'h04;
   localparam int TDP_ADR_W = 8;
   localparam int TDP_PTR_LSB = 2;
   localparam int TDP_CMD_TXE_BIT = 0;
   localparam int TDP_CMD_SRST_BIT = 1;
   localparam logic [31:0] TDP_PTR_RST = 32'h0000_0000;
   localparam logic [1:0] TDP_LOW_ZERO = 2'h0;
   localparam logic [29:0] TDP_NULL_LINK = 30'h0000_0000;
   typedef enum logic [1:0] {
      TDP_IDLE,
      TDP_FETCH,
      TDP_WAIT,
      TDP_PARKED
   } tdp_state_type;
endpackage

// ===== hdl/tdp_wb_slave.sv
// wishbone classic slave: decode and one-cycle registered ack
`timescale 1ns/1ps
module tdp_wb_slave
  import tdp_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // wishbone
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [tdp_pkg::TDP_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   output logic wb_ack_o,
   // decoded strobes, valid in the cycle before the ack is raised
   output logic acc_stb,
   output logic acc_we,
   output logic [tdp_pkg::TDP_ADR_W-1:0] acc_adr,
   output logic [3:0] acc_sel
);
   logic ack_ff;
   logic nxt_ack;
   // ack after one wait cycle, dropped the cycle after it is given
   always_comb
   begin
      nxt_ack = wb_cyc_i & wb_stb_i & ~ack_ff;
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ack_ff <= 1'b0;
      else
         ack_ff <= nxt_ack;
   end
   assign wb_ack_o = ack_ff;
   assign acc_stb = nxt_ack;
   assign acc_we = wb_we_i;
   assign acc_adr = wb_adr_i;
   assign acc_sel = wb_sel_i;
endmodule

// ===== hdl/tdp_tracker.sv
// transmit descriptor pointer tracker with wishbone register access
`timescale 1ns/1ps
module tdp_tracker
  import tdp_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [tdp_pkg::TDP_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // descriptor fetch logic
   output logic link_req,
   output logic [31:0] link_addr,
   input wire logic link_valid,
   input wire logic [31:0] link_data,
   input wire logic tx_done,
   // state to the transmit side
   output logic tx_active,
   output logic [31:0] tx_desc_pointer
);
   import tdp_pkg::*;

   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
         if (sel[i])
            r[i*8 +: 8] = new_v[i*8 +: 8];
      return r;
   endfunction

   logic acc_stb;
   logic acc_we;
   logic [TDP_ADR_W-1:0] acc_adr;
   logic [3:0] acc_sel;

   tdp_wb_slave u_wb (
      .clk(clk),
      .rst_n(rst_n),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_ack_o(wb_ack_o),
      .acc_stb(acc_stb),
      .acc_we(acc_we),
      .acc_adr(acc_adr),
      .acc_sel(acc_sel)
   );

   tdp_state_type state_ff, nxt_state;
   logic [29:0] ptr_ff, nxt_ptr;
   logic [31:0] dat_ff, nxt_dat;
   logic req_ff, nxt_req;
   logic act_ff, nxt_act;
   logic wr_ptr, wr_cmd, txe_wr, srst_wr;
   logic [31:0] ptr_word, merged;

   assign ptr_word = {ptr_ff, TDP_LOW_ZERO};
   assign wr_ptr = acc_stb & acc_we & (acc_adr == TDP_PTR_OFS);
   assign wr_cmd = acc_stb & acc_we & (acc_adr == TDP_CMD_OFS);
   assign txe_wr = wr_cmd & acc_sel[0] & wb_dat_i[TDP_CMD_TXE_BIT];
   assign srst_wr = wr_cmd & acc_sel[0] & wb_dat_i[TDP_CMD_SRST_BIT];
   assign merged = merge_bytes(ptr_word, wb_dat_i, acc_sel);

   always_comb
   begin
      nxt_state = state_ff;
      nxt_ptr = ptr_ff;
      nxt_req = 1'b0;
      case (state_ff)
         TDP_IDLE:
         begin
            // a load while active would race the walk, so only idle loads take
            if (wr_ptr)
               nxt_ptr = merged[31:TDP_PTR_LSB];
            if (txe_wr)
            begin
               nxt_state = TDP_FETCH;
               nxt_req = 1'b1;
            end
         end
         TDP_FETCH, TDP_WAIT:
         begin
            nxt_state = TDP_WAIT;
            if (link_valid)
            begin
               if (link_data[31:TDP_PTR_LSB] == TDP_NULL_LINK)
                  nxt_state = TDP_PARKED;
               else
               begin
                  nxt_ptr = link_data[31:TDP_PTR_LSB];
                  nxt_state = TDP_FETCH;
                  nxt_req = 1'b1;
               end
            end
         end
         TDP_PARKED:
         begin
            if (txe_wr)
            begin
               nxt_state = TDP_FETCH;
               nxt_req = 1'b1;
            end
            else if (tx_done)
               nxt_state = TDP_IDLE;
         end
         default:
            nxt_state = TDP_IDLE;
      endcase
      if (srst_wr)
      begin
         nxt_state = TDP_IDLE;
         nxt_ptr = TDP_PTR_RST[31:TDP_PTR_LSB];
         nxt_req = 1'b0;
      end
      nxt_act = (nxt_state != TDP_IDLE);
      nxt_dat = 32'h0000_0000;
      if (acc_stb & ~acc_we)
         case (acc_adr)
            TDP_PTR_OFS: nxt_dat = ptr_word;
            TDP_STAT_OFS: nxt_dat = {30'h0000_0000, state_ff == TDP_PARKED, act_ff};
            default: nxt_dat = 32'h0000_0000;
         endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff <= TDP_IDLE;
         ptr_ff <= TDP_PTR_RST[31:TDP_PTR_LSB];
         dat_ff <= 32'h0000_0000;
         req_ff <= 1'b0;
         act_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         ptr_ff <= nxt_ptr;
         dat_ff <= nxt_dat;
         req_ff <= nxt_req;
         act_ff <= nxt_act;
      end
   end

   assign wb_dat_o = dat_ff;
   assign link_req = req_ff;
   assign link_addr = ptr_word;
   assign tx_active = act_ff;
   assign tx_desc_pointer = ptr_word;

   a_ptr_low_zero: assert property (@(posedge clk) disable iff (!rst_n)
      tx_desc_pointer[1:0] == TDP_LOW_ZERO)
      else $error("pointer low bits not zero");
   a_null_holds: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == TDP_WAIT && link_valid && link_data[31:TDP_PTR_LSB] == TDP_NULL_LINK
       && !srst_wr)
      |=> $stable(ptr_ff) && state_ff == TDP_PARKED)
      else $error("null link moved pointer");
   a_link_advance: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == TDP_WAIT && link_valid && link_data[31:TDP_PTR_LSB] != TDP_NULL_LINK
       && !srst_wr)
      |=> ptr_ff == $past(link_data[31:TDP_PTR_LSB]) && link_req)
      else $error("pointer did not follow link");
   a_txe_reread: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == TDP_PARKED && txe_wr && !srst_wr) |=> link_req && $stable(ptr_ff))
      else $error("transmit enable did not reread link");
   a_load_idle: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_ptr && state_ff == TDP_IDLE && !srst_wr)
      |=> ptr_word == {$past(merged[31:TDP_PTR_LSB]), TDP_LOW_ZERO})
      else $error("idle load not taken");
   a_load_refused: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_ptr && state_ff == TDP_PARKED && !srst_wr) |=> $stable(ptr_ff))
      else $error("pointer load taken while busy");
   a_readback: assert property (@(posedge clk) disable iff (!rst_n)
      (acc_stb && !acc_we && acc_adr == TDP_PTR_OFS) |=> wb_ack_o && wb_dat_o == $past(ptr_word))
      else $error("pointer readback wrong");
endmodule

// ===== verification/tdp_desc_mem.sv
// host memory model holding a linked transmit descriptor list
`timescale 1ns/1ps
module tdp_desc_mem
(
   // clock
   input wire logic clk,
   // fetch side
   input wire logic link_req,
   input wire logic [31:0] link_addr,
   output logic link_valid,
   output logic [31:0] link_data,
   // bench access
   input wire logic slow,
   input wire logic mem_we,
   input wire logic [4:0] mem_idx,
   input wire logic [31:0] mem_val
);
   logic [31:0] mem [32];
   logic [31:0] addr_ff;
   int cnt = -1;
   initial link_valid = 1'b0;
   initial link_data = 32'h0;
   always @(posedge clk)
   begin
      if (mem_we)
         mem[mem_idx] <= mem_val;
      link_valid <= 1'b0;
      // a released bus inverts its previous value each cycle, so the last word returns every other cycle
      link_data <= ~link_data;
      if (link_req)
      begin
         addr_ff <= link_addr;
         cnt <= slow ? 6 : 0;
      end
      else if (cnt == 0)
      begin
         link_valid <= 1'b1;
         link_data <= mem[addr_ff[6:2]];
         cnt <= -1;
      end
      else if (cnt > 0)
         cnt <= cnt - 1;
   end
endmodule

// ===== verification/tdp_tracker_tb_top.sv
// bench for the transmit descriptor pointer tracker
`timescale 1ns/1ps
module tdp_tracker_tb_top;
   import tdp_pkg::*;
   logic clk, rst_n, cyc, stb, we, ack, lreq, lval, tx_done, act, slow, mwe;
   logic [7:0] adr;
   logic [4:0] midx;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, rd, laddr, ldat, ptr, mval;
   int miscompares = 0;
   int comparisons = 0;
   tdp_tracker i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .link_req(lreq), .link_addr(laddr), .link_valid(lval), .link_data(ldat),
      .tx_done(tx_done), .tx_active(act), .tx_desc_pointer(ptr));
   tdp_desc_mem i_mem (.clk(clk), .link_req(lreq), .link_addr(laddr), .link_valid(lval),
      .link_data(ldat), .slow(slow), .mem_we(mwe), .mem_idx(midx), .mem_val(mval));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic close_out();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      rd = rdat;
      if (ack !== 1'b1)
      begin
         miscompares++;
         close_out();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_stat(input logic [31:0] exp);
      int n;
      n = 0;
      do
      begin
         bus(1'b0, TDP_STAT_OFS, 32'h0);
         n++;
      end
      while ((rd & 32'h3) !== exp && n < 50);
      check(rd & 32'h3, exp);
   endtask
   task automatic put(input logic [4:0] i, input logic [31:0] v);
      mwe <= 1'b1;
      midx <= i;
      mval <= v;
      @(posedge clk);
      mwe <= 1'b0;
      @(posedge clk);
   endtask
   initial
   begin
      int n;
      rst_n = 1'b0;
      {cyc, stb, we, tx_done, slow, mwe} = 6'h0;
      adr = 8'h0;
      sel = 4'hf;
      wdat = 32'h0;
      midx = 5'h0;
      mval = 32'h0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      bus(1'b0, TDP_PTR_OFS, 32'h0);
      check(rd, TDP_PTR_RST);
      put(5'h04, 32'h20);
      put(5'h08, 32'h30);
      put(5'h0c, {TDP_NULL_LINK, TDP_LOW_ZERO});
      bus(1'b1, TDP_PTR_OFS, 32'h13);
      bus(1'b0, TDP_PTR_OFS, 32'h0);
      check(rd, 32'h10);
      check(ptr, 32'h10);
      slow <= 1'b1;
      bus(1'b1, TDP_CMD_OFS, 32'h1);
      check({31'h0, act}, 32'h1);
      wait_stat(32'h3);
      bus(1'b0, TDP_PTR_OFS, 32'h0);
      check(rd, 32'h30);
      check(laddr, 32'h30);
      bus(1'b1, TDP_PTR_OFS, 32'h50);
      bus(1'b0, TDP_PTR_OFS, 32'h0);
      check(rd, 32'h30);
      put(5'h0c, 32'h40);
      put(5'h10, 32'h0);
      slow <= 1'b0;
      bus(1'b1, TDP_CMD_OFS, 32'h1);
      n = 0;
      while (ptr !== 32'h40 && n < 30)
      begin
         @(posedge clk);
         n++;
      end
      check(ptr, 32'h40);
      wait_stat(32'h3);
      tx_done <= 1'b1;
      @(posedge clk);
      tx_done <= 1'b0;
      wait_stat(32'h0);
      bus(1'b1, TDP_PTR_OFS, 32'h20);
      bus(1'b0, TDP_PTR_OFS, 32'h0);
      check(rd, 32'h20);
      bus(1'b1, TDP_CMD_OFS, 32'h2);
      bus(1'b0, TDP_PTR_OFS, 32'h0);
      check(rd, 32'h0);
      sel <= 4'h2;
      bus(1'b1, TDP_PTR_OFS, 32'h0000_ab13);
      sel <= 4'hf;
      bus(1'b0, TDP_PTR_OFS, 32'h0);
      check(rd, 32'h0000_ab00);
      bus(1'b0, 8'h3c, 32'h0);
      check(rd, 32'h0);
      close_out();
   end
endmodule
